// file: shared/alfe_pkg.sv
// ----------------------------------------------------------------
// Constants and types of the ASCII link frame engine
// ----------------------------------------------------------------
package alfe_pkg;

  // Control characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_LF  = 8'h0a;
  localparam logic [7:0] CH_CR  = 8'h0d;
  localparam logic [7:0] CH_NAK = 8'h15;

  // Error codes sent after the negative acknowledge
  localparam logic [3:0] ERR_SUM   = 4'h2;
  localparam logic [3:0] ERR_PROTO = 4'h3;
  localparam logic [3:0] ERR_CHAR  = 4'h7;

  // Data field formats (write A/A1/A2, read reply E/E1/E2)
  localparam logic [1:0] FMT_FOUR = 2'h0;
  localparam logic [1:0] FMT_TWO  = 2'h1;
  localparam logic [1:0] FMT_SIX  = 2'h2;

  // Frame layout
  localparam logic [4:0] HDR_LEN      = 5'h04;
  localparam int         WRITE_BIT    = 7;
  localparam logic [4:0] ACK_BODY     = 5'h03;
  localparam logic [4:0] NAK_BODY     = 5'h04;
  localparam logic [4:0] READ_FIXED   = 5'h06;
  localparam int         BUF_WIDTH    = 8;

  // Reply waiting time: 10 ms steps, 0 to 15 steps
  localparam int CLK_HZ           = 25_000_000;
  localparam int WAIT_STEP_MS     = 10;
  localparam int WAIT_STEP_CYCLES = CLK_HZ / 1000 * WAIT_STEP_MS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_APP  = 3'h3,
    ST_HOLD = 3'h2,
    ST_TX   = 3'h6,
    ST_ANS  = 3'h4
  } alfe_state_e;

  typedef enum logic [1:0] {
    RK_ACK  = 2'h0,
    RK_NAK  = 2'h1,
    RK_READ = 2'h2
  } alfe_reply_e;

  // Data field length in characters
  function automatic logic [4:0] data_len(input logic [1:0] fmt);
    data_len = (fmt == FMT_TWO) ? 5'h02 : (fmt == FMT_SIX) ? 5'h06 : 5'h04;
  endfunction : data_len

  // Uppercase hex digit check
  function automatic logic hex_ok(input logic [7:0] c);
    hex_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction : hex_ok

  // Hex digit to nibble
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = (c <= 8'h39) ? c - 8'h30 : c - 8'h37;
    hex_val = v[3:0];
  endfunction : hex_val

  // Nibble to uppercase hex digit
  function automatic logic [7:0] nib_hex(input logic [3:0] n);
    nib_hex = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : nib_hex

endpackage : alfe_pkg

// file: rtl/alfe_buf2.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-entry buffer between the frame builder and the transmitter
// ----------------------------------------------------------------
module alfe_buf2 (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_b,
  input  wire logic                           in_valid,
  output logic                                in_ready,
  input  wire logic [alfe_pkg::BUF_WIDTH-1:0] in_data,
  output logic                                out_valid,
  input  wire logic                           out_ready,
  output logic      [alfe_pkg::BUF_WIDTH-1:0] out_data
);

  logic [alfe_pkg::BUF_WIDTH-1:0] mem_q [2];
  logic                           wp_q;
  logic                           rp_q;
  logic [1:0]                     cnt_q;
  logic                           push;
  logic                           pop;

  // Handshakes
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      if (push && !pop) cnt_q <= cnt_q + 2'h1;
      else if (pop && !push) cnt_q <= cnt_q - 2'h1;
    end
  end

endmodule : alfe_buf2

// file: rtl/alfe_frame_engine.sv
`timescale 1ns/1ps
// Summary of operation
// - Write request is ENQ, station, instruction, wait char, data, sum, terminator.
// - Good request answered with ACK, station and optional terminator.
// - Bad request answered with NAK, station, error code, optional terminator.
// - Read reply is STX, station, four/two/six data, ETX, sum, terminator.
// - STX is 02 and ETX is 03, bracketing read data.
// - ENQ 05 opens every request; ACK 06 means no error.
// - NAK 15 means a data error was found.
// - Terminator is CR 0D then LF 0A, presence set by configuration.
// - A configuration input selects terminator present or absent.
// - Station is two hex characters 00 to 1F; only own station answered.
// - Wait char delays the reply 0 to 150 ms in 10 ms steps.
// - Without the wait char the frame is one shorter; configured delay used.
// - Instruction code selects the operation and meaning of the data.
// - Check time before replying depends on the instruction code.
// - Sum check is two hex characters, low byte of character sum.
// - Nothing is sent except as a reply to a host request.
module alfe_frame_engine #(
  parameter int WAIT_STEP_CYCLES = alfe_pkg::WAIT_STEP_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [4:0]  station_addr,
  input  wire logic        terminator_select,
  input  wire logic        wait_char_present,
  input  wire logic [3:0]  reply_wait_setting,
  input  wire logic [1:0]  data_format,
  output logic             req_valid,
  output logic             req_write,
  output logic [7:0]       req_instr,
  output logic [23:0]      req_data,
  input  wire logic        app_done,
  input  wire logic        app_error,
  input  wire logic [3:0]  app_err_code,
  input  wire logic        app_no_reply,
  input  wire logic [23:0] app_rd_data,
  output logic             host_ack,
  output logic             host_nak
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = $clog2(WAIT_STEP_CYCLES);

  alfe_pkg::alfe_state_e state_q;
  alfe_pkg::alfe_reply_e kind_q;

  logic [4:0]    idx_q;
  logic [7:0]    sum_q;
  logic [3:0]    rsum_q;
  logic          err_q;
  logic [3:0]    ecode_q;
  logic [7:0]    st_q;
  logic          st_bad_q;
  logic [7:0]    instr_q;
  logic [3:0]    wait_q;
  logic [23:0]   data_q;
  logic          is_ack_q;
  logic          awaiting_q;
  logic          req_valid_q;
  logic          host_ack_q;
  logic          host_nak_q;
  logic [3:0]    wait_left_q;
  logic [CW-1:0] wcyc_q;
  logic [4:0]    tx_idx_q;
  logic [7:0]    txsum_q;
  logic [23:0]   rdd_q;
  logic [3:0]    tx_code_q;

  logic          take;
  logic          hexv;
  logic [3:0]    nib;
  logic [4:0]    dl;
  logic [4:0]    body_len;
  logic [4:0]    term_base;
  logic [4:0]    last_idx;
  logic [4:0]    term_len;
  logic          is_last;
  logic          bad_now;
  logic [3:0]    code_now;
  logic          fail_now;
  logic [7:0]    st_cur;
  logic          discard;
  logic          frame_start;
  logic          rx_done;

  logic [4:0]    tx_body;
  logic [4:0]    tx_len;
  logic [7:0]    tx_ch;
  logic [4:0]    k;
  logic [23:0]   shifted;
  logic          buf_in_valid;
  logic          buf_in_ready;
  logic          push;
  logic          tx_last;

  // ----------------------------------------------------------------
  // Receive field decode
  // ----------------------------------------------------------------
  // Characters come from a same-clock receiver; never stalled
  assign rx_ready = 1'b1;
  assign take     = rx_valid;
  assign hexv     = alfe_pkg::hex_ok(rx_data);
  assign nib      = alfe_pkg::hex_val(rx_data);
  assign dl       = alfe_pkg::data_len(data_format);
  assign term_len = terminator_select ? 5'h02 : 5'h00;

  // Body: station, instruction, optional wait char, data on writes only
  assign body_len = alfe_pkg::HDR_LEN + {4'h0, wait_char_present}
                  + (instr_q[alfe_pkg::WRITE_BIT] ? dl : 5'h00);

  // Host answer has only a station; requests add two sum characters
  assign term_base = (state_q == alfe_pkg::ST_ANS) ? 5'h02 : body_len + 5'h02;
  assign last_idx  = term_base + term_len - 5'h01;
  assign is_last   = (idx_q == last_idx);
  assign st_cur    = (idx_q == 5'h01) ? {st_q[3:0], nib} : st_q;
  assign frame_start = take && (rx_data == alfe_pkg::CH_ENQ);

  // Error detection on the current character, first error wins
  always_comb begin
    bad_now  = 1'b0;
    code_now = ecode_q;
    if (idx_q < term_base) begin
      if (!hexv) begin
        bad_now  = 1'b1;
        code_now = alfe_pkg::ERR_CHAR;
      end else if (state_q == alfe_pkg::ST_RX && idx_q == body_len + 5'h01
                   && {rsum_q, nib} != sum_q) begin
        bad_now  = 1'b1;
        code_now = alfe_pkg::ERR_SUM;
      end
    end else if (rx_data != ((idx_q == term_base) ? alfe_pkg::CH_CR : alfe_pkg::CH_LF)) begin
      bad_now  = 1'b1;
      code_now = alfe_pkg::ERR_PROTO;
    end
    if (err_q) code_now = ecode_q;
  end

  assign fail_now = err_q || bad_now;
  assign discard  = st_bad_q || (idx_q < 5'h02 && !hexv)
                 || (st_cur != {3'h0, station_addr});
  assign rx_done  = (state_q == alfe_pkg::ST_RX) && take && !frame_start && is_last;

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  // Transmission only ever follows a received request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= alfe_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        alfe_pkg::ST_IDLE: begin
          if (frame_start) state_q <= alfe_pkg::ST_RX;
          else if (take && awaiting_q && (rx_data == alfe_pkg::CH_ACK
                   || rx_data == alfe_pkg::CH_NAK)) state_q <= alfe_pkg::ST_ANS;
        end
        alfe_pkg::ST_RX: begin
          if (rx_done) begin
            if (discard) state_q <= alfe_pkg::ST_IDLE;
            else if (fail_now) state_q <= alfe_pkg::ST_HOLD;
            else state_q <= alfe_pkg::ST_APP;
          end
        end
        alfe_pkg::ST_APP: begin
          // Application takes an instruction-dependent check time
          if (app_done) state_q <= app_no_reply ? alfe_pkg::ST_IDLE : alfe_pkg::ST_HOLD;
        end
        alfe_pkg::ST_HOLD: begin
          if (wait_left_q == 4'h0) state_q <= alfe_pkg::ST_TX;
        end
        alfe_pkg::ST_TX: begin
          if (push && tx_last) state_q <= alfe_pkg::ST_IDLE;
        end
        alfe_pkg::ST_ANS: begin
          if (take && is_last) state_q <= alfe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Field capture and running sum
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idx_q    <= 5'h00;
      sum_q    <= 8'h00;
      rsum_q   <= 4'h0;
      err_q    <= 1'b0;
      ecode_q  <= 4'h0;
      st_q     <= 8'h00;
      st_bad_q <= 1'b0;
      instr_q  <= 8'h00;
      wait_q   <= 4'h0;
      data_q   <= 24'h000000;
      is_ack_q <= 1'b0;
    end else if (take && (state_q == alfe_pkg::ST_IDLE || (frame_start && state_q == alfe_pkg::ST_RX))) begin
      // Any character in idle, or an ENQ while receiving, restarts the parse
      idx_q    <= 5'h00;
      sum_q    <= 8'h00;
      err_q    <= 1'b0;
      ecode_q  <= 4'h0;
      st_bad_q <= 1'b0;
      instr_q  <= 8'h00;
      data_q   <= 24'h000000;
      is_ack_q <= (rx_data == alfe_pkg::CH_ACK);
    end else if (take && (state_q == alfe_pkg::ST_RX || state_q == alfe_pkg::ST_ANS)) begin
      idx_q   <= idx_q + 5'h01;
      err_q   <= fail_now;
      ecode_q <= code_now;
      // Sum covers station, instruction, wait char and data
      if (state_q == alfe_pkg::ST_RX && (idx_q < alfe_pkg::HDR_LEN || idx_q < body_len))
        sum_q <= sum_q + rx_data;
      if (idx_q < 5'h02) begin
        st_q <= {st_q[3:0], nib};
        if (!hexv) st_bad_q <= 1'b1;
      end else if (state_q == alfe_pkg::ST_RX) begin
        if (idx_q < alfe_pkg::HDR_LEN) instr_q <= {instr_q[3:0], nib};
        else if (wait_char_present && idx_q == alfe_pkg::HDR_LEN) wait_q <= nib;
        else if (idx_q < body_len) data_q <= {data_q[19:0], nib};
        else if (idx_q == body_len) rsum_q <= nib;
      end
    end
  end

  // ----------------------------------------------------------------
  // Application request and host answer pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_valid_q <= 1'b0;
      host_ack_q  <= 1'b0;
      host_nak_q  <= 1'b0;
    end else begin
      req_valid_q <= rx_done && !discard && !fail_now;
      host_ack_q  <= 1'b0;
      host_nak_q  <= 1'b0;
      if (state_q == alfe_pkg::ST_ANS && take && is_last && !fail_now && !discard) begin
        host_ack_q <= is_ack_q;
        host_nak_q <= !is_ack_q;
      end
    end
  end

  assign req_valid = req_valid_q;
  assign req_write = instr_q[alfe_pkg::WRITE_BIT];
  assign req_instr = instr_q;
  assign req_data  = data_q;
  assign host_ack  = host_ack_q;
  assign host_nak  = host_nak_q;

  // ----------------------------------------------------------------
  // Reply waiting time, counted from the end of the request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_left_q <= 4'h0;
      wcyc_q      <= '0;
    end else if (rx_done && !discard) begin
      wait_left_q <= wait_char_present ? wait_q : reply_wait_setting;
      wcyc_q      <= '0;
    end else if (wait_left_q != 4'h0) begin
      if (wcyc_q == CW'(WAIT_STEP_CYCLES - 1)) begin
        wcyc_q      <= '0;
        wait_left_q <= wait_left_q - 4'h1;
      end else begin
        wcyc_q <= wcyc_q + CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      kind_q    <= alfe_pkg::RK_ACK;
      rdd_q     <= 24'h000000;
      tx_code_q <= 4'h0;
    end else if (rx_done && fail_now) begin
      kind_q    <= alfe_pkg::RK_NAK;
      tx_code_q <= code_now;
    end else if (state_q == alfe_pkg::ST_APP && app_done) begin
      rdd_q     <= app_rd_data;
      tx_code_q <= app_err_code;
      if (app_error) kind_q <= alfe_pkg::RK_NAK;
      else if (instr_q[alfe_pkg::WRITE_BIT]) kind_q <= alfe_pkg::RK_ACK;
      else kind_q <= alfe_pkg::RK_READ;
    end
  end

  // ----------------------------------------------------------------
  // Reply character generator
  // ----------------------------------------------------------------
  always_comb begin
    unique case (kind_q)
      alfe_pkg::RK_ACK: tx_body = alfe_pkg::ACK_BODY;
      alfe_pkg::RK_NAK: tx_body = alfe_pkg::NAK_BODY;
      default:          tx_body = alfe_pkg::READ_FIXED + dl;
    endcase
  end

  assign tx_len  = tx_body + term_len;
  assign tx_last = (tx_idx_q == tx_len - 5'h01);
  assign k       = tx_idx_q - 5'h03;
  assign shifted = rdd_q >> {dl - k - 5'h01, 2'h0};

  // Character at the current reply position
  always_comb begin
    if (tx_idx_q >= tx_body) begin
      tx_ch = (tx_idx_q == tx_body) ? alfe_pkg::CH_CR : alfe_pkg::CH_LF;
    end else if (tx_idx_q == 5'h00) begin
      unique case (kind_q)
        alfe_pkg::RK_ACK: tx_ch = alfe_pkg::CH_ACK;
        alfe_pkg::RK_NAK: tx_ch = alfe_pkg::CH_NAK;
        default:          tx_ch = alfe_pkg::CH_STX;
      endcase
    end else if (tx_idx_q == 5'h01) begin
      tx_ch = alfe_pkg::nib_hex({3'h0, station_addr[4]});
    end else if (tx_idx_q == 5'h02) begin
      tx_ch = alfe_pkg::nib_hex(station_addr[3:0]);
    end else if (kind_q == alfe_pkg::RK_NAK) begin
      tx_ch = alfe_pkg::nib_hex(tx_code_q);
    end else if (k < dl) begin
      tx_ch = alfe_pkg::nib_hex(shifted[3:0]);
    end else if (k == dl) begin
      tx_ch = alfe_pkg::CH_ETX;
    end else if (k == dl + 5'h01) begin
      tx_ch = alfe_pkg::nib_hex(txsum_q[7:4]);
    end else begin
      tx_ch = alfe_pkg::nib_hex(txsum_q[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // Reply sequencing into the buffer
  // ----------------------------------------------------------------
  assign buf_in_valid = (state_q == alfe_pkg::ST_TX);
  assign push         = buf_in_valid && buf_in_ready;

  // Position and running sum of the read reply
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_idx_q <= 5'h00;
      txsum_q  <= 8'h00;
    end else if (state_q != alfe_pkg::ST_TX) begin
      tx_idx_q <= 5'h00;
      txsum_q  <= 8'h00;
    end else if (push) begin
      tx_idx_q <= tx_idx_q + 5'h01;
      if (tx_idx_q != 5'h00 && tx_idx_q < dl + 5'h03)
        txsum_q <= txsum_q + tx_ch;
    end
  end

  // Host owes an answer after a read reply
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awaiting_q <= 1'b0;
    end else if (state_q == alfe_pkg::ST_TX && push && tx_last) begin
      awaiting_q <= (kind_q == alfe_pkg::RK_READ);
    end else if (state_q == alfe_pkg::ST_IDLE && take) begin
      awaiting_q <= 1'b0;
    end
  end

  // Stall toward the transmitter loses no character
  alfe_buf2 u_buf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (tx_ch),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

endmodule : alfe_frame_engine

// file: tb/alfe_frame_engine_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker of the frame engine
// ----------------------------------------
module alfe_frame_engine_chk (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        rx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [7:0]  req_instr,
  input wire logic [23:0] req_data,
  input wire logic        host_ack,
  input wire logic        host_nak
);
  logic seen_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Marks that the host has sent something since reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) seen_q <= 1'b0;
    else if (rx_valid) seen_q <= 1'b1;
  end
  req_pulse_a: assert property (req_valid |=> !req_valid)
    else $error("request strobe longer than one cycle");
  write_flag_a: assert property (req_valid |-> req_write == req_instr[7])
    else $error("write flag differs from instruction top bit");
  read_nodata_a: assert property (req_valid && !req_write |-> req_data == 24'h000000)
    else $error("read request carries data");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply character dropped while stalled");
  host_excl_a: assert property (!(host_ack && host_nak))
    else $error("host answer flagged both ways");
  host_pulse_a: assert property (host_ack || host_nak |=> !host_ack && !host_nak && $past(rx_valid, 2))
    else $error("host answer strobe too long or without a frame");
  quiet_link_a: assert property (tx_valid || req_valid |-> seen_q)
    else $error("output produced before any request");
  reply_open_a: assert property ($rose(tx_valid) |-> tx_data inside {8'h02, 8'h06, 8'h15})
    else $error("reply opens without a control code");
  req_cause_a: assert property ($rose(req_valid) |-> $past(rx_valid))
    else $error("request strobe not right after a character");
endmodule : alfe_frame_engine_chk

bind alfe_frame_engine alfe_frame_engine_chk u_chk (.clk_sys, .rst_b, .rx_valid, .tx_data, .tx_valid,
  .tx_ready, .req_valid, .req_write, .req_instr, .req_data, .host_ack, .host_nak);

// file: tb/alfe_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side reply sink with random stalls
// ----------------------------------------
module alfe_host_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       stall_en,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            got,
  output logic [7:0]      got_data
);
  logic [7:0] st_q;
  // A slow host stops taking characters now and then
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= 8'h5b;
      tx_ready <= 1'b0;
      got      <= 1'b0;
      got_data <= 8'h00;
    end else begin
      st_q     <= {st_q[6:0], st_q[7] ^ st_q[5] ^ st_q[4] ^ st_q[3]};
      tx_ready <= !stall_en || st_q[0];
      got      <= tx_valid && tx_ready;
      got_data <= tx_data;
    end
  end
endmodule : alfe_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench of the frame engine
// ----------------------------------------
module testbench;
  logic        clk_sys = 1'b0, rst_b = 1'b0, rx_valid = 1'b0, app_done = 1'b0, app_error = 1'b0;
  logic        app_no_reply = 1'b0, stall_en = 1'b1, terminator_select = 1'b0, wait_char_present = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic [4:0]  station_addr = 5'h00;
  logic [3:0]  reply_wait_setting = 4'h2, app_err_code = 4'h0;
  logic [1:0]  data_format = 2'h0;
  logic [23:0] app_rd_data = 24'h000000;
  logic        rx_ready, tx_valid, tx_ready, req_valid, req_write, host_ack, host_nak, got;
  logic [7:0]  tx_data, req_instr, got_data, sm;
  logic [23:0] req_data;
  logic [15:0] lf = 16'h000a;
  logic [7:0]  tq[$], eq[$], rq[$];
  int          bad_count = 0, tests_run = 0, cyc = 0;

  always #20 clk_sys = ~clk_sys;
  alfe_frame_engine #(.WAIT_STEP_CYCLES(8)) dut (.clk_sys, .rst_b, .rx_data, .rx_valid, .rx_ready, .tx_data,
    .tx_valid, .tx_ready, .station_addr, .terminator_select, .wait_char_present, .reply_wait_setting,
    .data_format, .req_valid, .req_write, .req_instr, .req_data, .app_done, .app_error, .app_err_code,
    .app_no_reply, .app_rd_data, .host_ack, .host_nak);
  alfe_host_model host (.clk_sys, .rst_b, .stall_en, .tx_valid, .tx_data, .tx_ready, .got, .got_data);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] hx(input logic [3:0] v);
    hx = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction : hx
  task automatic put_hex(ref logic [7:0] q[$], input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      q.push_back(hx(v[i*4 +: 4]));
      sm = sm + hx(v[i*4 +: 4]);
    end
  endtask : put_hex
  task automatic put_end(ref logic [7:0] q[$], input logic t);
    if (t) begin
      q.push_back(8'h0d);
      q.push_back(8'h0a);
    end
  endtask : put_end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Sends the queued characters back to back
  task automatic send();
    rq.delete();
    foreach (tq[i]) begin
      @(posedge clk_sys);
      rx_data  <= tq[i];
      rx_valid <= 1'b1;
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    tq.delete();
  endtask : send
  task automatic request(input logic [4:0] s, input logic [7:0] ins, input logic [23:0] dv, input int n,
                         input logic [3:0] w, input logic [7:0] skew);
    tq.push_back(8'h05);
    sm = 8'h00;
    put_hex(tq, {19'h0, s}, 2);
    put_hex(tq, {16'h0, ins}, 2);
    if (wait_char_present) put_hex(tq, {20'h0, w}, 1);
    if (ins[7]) put_hex(tq, dv, n);
    put_hex(tq, {16'h0, sm + skew}, 2);
    put_end(tq, terminator_select);
    send();
  endtask : request
  task automatic wait_pulse();
    for (int k = 0; k < 6; k++) begin
      #1;
      if ((req_valid | host_ack | host_nak) === 1'b1) break;
      @(posedge clk_sys);
    end
  endtask : wait_pulse
  task automatic answer(input logic err, input logic nr, output int k);
    @(posedge clk_sys);
    app_error <= err;
    app_no_reply <= nr;
    app_done  <= 1'b1;
    @(posedge clk_sys);
    app_done  <= 1'b0;
    for (k = 2; tx_valid !== 1'b1 && k < 400; k++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : answer
  task automatic reply_head(input logic [7:0] c, input logic [4:0] s);
    eq.push_back(c);
    put_hex(eq, {19'h0, s}, 2);
  endtask : reply_head
  task automatic chk_reply();
    for (int k = 0; k < 400 && rq.size() < eq.size(); k++) @(posedge clk_sys);
    chk("reply length", eq.size(), rq.size());
    foreach (eq[i]) if (i < rq.size()) chk("reply char", eq[i], rq[i]);
    eq.delete();
  endtask : chk_reply

  // Collects taken reply characters and cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (got) rq.push_back(got_data);
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // Main sequence: one pass for each data field width
  initial begin
    logic [4:0]  st;
    logic [7:0]  ins;
    logic [23:0] dv;
    logic [3:0]  w;
    int          n, k;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      lf = lfsr(lfsr(lf));
      st = lf[4:0];
      w  = {2'h0, lf[9:8]};
      n  = (f == 1) ? 2 : (f == 2) ? 6 : 4;
      dv = {lf, lf[15:8]} & ((24'h1 << (4 * n)) - 24'h1);
      ins = {1'b0, lf[14:8]};
      @(posedge clk_sys);
      station_addr      <= st;
      data_format       <= f[1:0];
      terminator_select <= f[0];
      wait_char_present <= (f == 2);
      app_rd_data       <= dv;
      app_err_code      <= lf[3:0];
      reply_wait_setting <= (f == 2) ? 4'hf : w;
      stall_en          <= (f != 1);
      @(posedge clk_sys);
      request(st, ins, dv, n, w, 8'h00);
      wait_pulse();
      chk("req_valid", 1, req_valid);
      chk("req_write", 0, req_write);
      chk("req_instr", ins, req_instr);
      answer(1'b0, 1'b0, k);
      chk("reply delay", 1, k >= int'(w) * 8 - 1 && k <= int'(w) * 8 + 8);
      eq.push_back(8'h02);
      sm = 8'h00;
      put_hex(eq, {19'h0, st}, 2);
      put_hex(eq, dv, n);
      eq.push_back(8'h03);
      put_hex(eq, {16'h0, sm}, 2);
      put_end(eq, f[0]);
      chk_reply();
      tq.push_back(f == 1 ? 8'h15 : 8'h06);
      put_hex(tq, {19'h0, st}, 2);
      put_end(tq, f[0]);
      send();
      wait_pulse();
      chk("host_ack", f != 1, host_ack);
      chk("host_nak", f == 1, host_nak);
      ins = {1'b1, lf[6:0]};
      request(st, ins, dv, n, w, 8'h00);
      wait_pulse();
      chk("req_write", 1, req_write);
      chk("req_data", dv, req_data);
      answer(f == 2, 1'b0, k);
      reply_head(f == 2 ? 8'h15 : 8'h06, st);
      if (f == 2) eq.push_back(hx(lf[3:0]));
      put_end(eq, f[0]);
      chk_reply();
      request(st, ins, dv, n, w, 8'h01);
      wait_pulse();
      chk("req_valid", 0, req_valid);
      reply_head(8'h15, st);
      eq.push_back(8'h32);
      put_end(eq, f[0]);
      chk_reply();
      request(st ^ 5'h10, ins, dv, n, w, 8'h00);
      repeat (60) @(posedge clk_sys);
      chk("dropped frame", 0, rq.size());
      request(st, ins, dv, n, w, 8'h00);
      answer(1'b0, 1'b1, k);
      chk("silent reply", 400, k);
      $display("test %0d done", f);
    end
    close_out();
  end
endmodule : testbench
